// ===== rtl/rss_delay_cnt.sv
// reset stretch counter, restarted from zero by any active source
`default_nettype none
module rss_delay_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  rss_dly_if.cnt dly
);
  logic [31:0] count_ff;
  logic done_ff;
  assign dly.count = count_ff;
  assign dly.done = done_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n || dly.restart)
    begin
      count_ff <= 32'h0;
      done_ff <= 1'b0;
    end
    else if (count_ff >= dly.load_cyc)
    begin
      done_ff <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/rss_dly_if.sv
// delay counter control between sequencer and counter
`default_nettype none
interface rss_dly_if;
  logic restart;
  logic [31:0] load_cyc;
  logic done;
  logic [31:0] count;
  modport ctl (output restart, output load_cyc, input done, input count);
  modport cnt (input restart, input load_cyc, output done, output count);
endinterface
`default_nettype wire

// ===== rtl/rss_pkg.sv
// constants and types of the reset source sequencer
`default_nettype none
package rss_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_MHZ = 40;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CAUSE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DELAY_OFS = 8'h0C;
  // ==========================================================
  // field positions
  localparam int unsigned CTRL_BOD_EN_BIT = 0;
  localparam int unsigned CTRL_WDT_EN_BIT = 1;
  localparam int unsigned SRC_POR_BIT = 0;
  localparam int unsigned SRC_EXT_BIT = 1;
  localparam int unsigned SRC_WDT_BIT = 2;
  localparam int unsigned SRC_BOD_BIT = 3;
  localparam int unsigned SRC_SCAN_BIT = 4;
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned STATUS_STATE_LSB = 5;
  localparam int unsigned STATUS_CORE_BIT = 7;
  // ==========================================================
  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [4:0] CAUSE_RESET = 5'h01;
  localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
  // ==========================================================
  // timing: figures in ns or us, counts rounded up
  localparam int unsigned EXT_MIN_NS = 2500;
  localparam int unsigned EXT_MIN_CYC = (EXT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOD_MIN_NS = 2000;
  localparam int unsigned BOD_MIN_CYC = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TOUT_A_US = 4;
  localparam int unsigned TOUT_A_CYC = TOUT_A_US * CLK_MHZ;
  localparam int unsigned TOUT_B_US = 100;
  localparam int unsigned TOUT_B_CYC = TOUT_B_US * CLK_MHZ;
  localparam int unsigned TOUT_C_US = 4100;
  localparam int unsigned TOUT_C_CYC = TOUT_C_US * CLK_MHZ;
  localparam int unsigned TOUT_D_US = 65000;
  localparam int unsigned TOUT_D_CYC = TOUT_D_US * CLK_MHZ;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN = 2'b10
  } rss_state_t;
endpackage
`default_nettype wire

// ===== rtl/rss_seq.sv
// reset source sequencer top with AXI4-Lite register slave
// How it works
// - I/O registers held at initial values in reset; release starts code at reset vector.
// - I/O ports reset combinationally from supply, pin, scan and watchdog sources, no clock needed; brown-out goes through its clocked filter.
// - after all sources clear, internal reset stretched by fuse-selected delay.
// - five causes: power-on, pin, watchdog, brown-out, scan-chain register.
// - power-on threshold starts delay; supply drop reasserts reset at once.
// - pin low past minimum width resets; shorter pulses may be ignored.
// - pin rising starts delay counter; core released after time-out.
// - watchdog expiry resets only when watchdog enabled.
// - brown-out asserts after minimum duration below trigger, releases above upper level.
// - brown-out dips shorter than minimum duration are ignored.
// - brown-out level chosen by fuses with hysteresis around it.
// - reset held while scan-chain reset register holds one.
// - watchdog reset lasts while wdt_timeout is high; delay starts at its fall.
`default_nettype none
module rss_seq #(
  parameter int unsigned DLY_C_CYC = rss_pkg::TOUT_C_CYC,
  parameter int unsigned DLY_D_CYC = rss_pkg::TOUT_D_CYC,
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic por_supply_ok,
  input wire logic ext_reset_pin_n,
  input wire logic wdt_timeout,
  input wire logic wdt_reset_en,
  input wire logic bod_below_trigger,
  input wire logic bod_above_upper,
  input wire logic scan_reset_bit,
  // fuses
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_source_fuses,
  input wire logic [2:0] brownout_level_fuses,
  // reset outputs
  output logic io_reset_n,
  output logic core_reset_n,
  output logic core_pc_load,
  output logic [31:0] core_pc,
  output logic [2:0] brownout_level_sel,
  output logic brownout_detector_en
);
  // ==========================================================
  // declarations
  logic por_ok_s;
  logic pin_n_s;
  logic below_s;
  logic above_s;
  logic scan_s;
  logic [1:0] ctrl_ff;
  logic [4:0] cause_ff;
  logic [4:0] nxt_cause;
  logic [7:0] ext_cnt_ff;
  logic ext_low_ff;
  logic [7:0] bod_cnt_ff;
  logic bod_ff;
  logic wdt_hit;
  logic [4:0] src_vec;
  logic src_any;
  logic core_n_ff;
  logic pc_load_ff;
  rss_pkg::rss_state_t state_ff;
  rss_pkg::rss_state_t nxt_state;
  logic [31:0] sel_cyc;
  logic [1:0] dly_idx;
  rss_dly_if dly ();
  // ==========================================================
  // input synchronisers
  rss_sync2 #(.W(5), .INIT(5'b00010)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({scan_reset_bit, bod_above_upper, bod_below_trigger, ext_reset_pin_n, por_supply_ok}),
    .q({scan_s, above_s, below_s, pin_n_s, por_ok_s})
  );
  // ==========================================================
  // delay selection
  function automatic logic [31:0] tout_cycles(input logic [1:0] idx);
    logic [31:0] c;
    c = 32'h0;
    unique case (idx)
      2'h0: c = 32'(rss_pkg::TOUT_A_CYC);
      2'h1: c = 32'(rss_pkg::TOUT_B_CYC);
      2'h2: c = 32'(DLY_C_CYC);
      2'h3: c = 32'(DLY_D_CYC);
    endcase
    return c;
  endfunction
  // crystal sources need at least the third delay step
  assign dly_idx = (clock_source_fuses[3] && startup_time_fuses < 2'h2) ? 2'h2 : startup_time_fuses;
  assign sel_cyc = tout_cycles(dly_idx);
  // ==========================================================
  // brown-out fuse decode
  assign brownout_level_sel = brownout_level_fuses;
  assign brownout_detector_en = (brownout_level_fuses != rss_pkg::BOD_FUSE_OFF)
    && ctrl_ff[rss_pkg::CTRL_BOD_EN_BIT];
  // ==========================================================
  // external pin filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pin_n_s)
    begin
      ext_cnt_ff <= 8'h0;
      ext_low_ff <= 1'b0;
    end
    else if (ext_cnt_ff >= 8'(rss_pkg::EXT_MIN_CYC - 1))
    begin
      ext_low_ff <= 1'b1;
    end
    else
    begin
      ext_cnt_ff <= ext_cnt_ff + 8'h1;
    end
  end
  // ==========================================================
  // brown-out filter with hysteresis
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !brownout_detector_en)
    begin
      bod_cnt_ff <= 8'h0;
      bod_ff <= 1'b0;
    end
    else if (bod_ff)
    begin
      bod_cnt_ff <= 8'h0;
      bod_ff <= !above_s;
    end
    else if (!below_s)
    begin
      bod_cnt_ff <= 8'h0;
    end
    else if (bod_cnt_ff >= 8'(rss_pkg::BOD_MIN_CYC - 1))
    begin
      bod_ff <= 1'b1;
    end
    else
    begin
      bod_cnt_ff <= bod_cnt_ff + 8'h1;
    end
  end
  // ==========================================================
  // source combination
  assign wdt_hit = wdt_timeout && wdt_reset_en && ctrl_ff[rss_pkg::CTRL_WDT_EN_BIT];
  assign src_vec[rss_pkg::SRC_POR_BIT] = !por_ok_s;
  assign src_vec[rss_pkg::SRC_EXT_BIT] = ext_low_ff;
  assign src_vec[rss_pkg::SRC_WDT_BIT] = wdt_hit;
  assign src_vec[rss_pkg::SRC_BOD_BIT] = bod_ff;
  assign src_vec[rss_pkg::SRC_SCAN_BIT] = scan_s;
  assign src_any = |src_vec;
  // port reset asserts from raw pins without any clock; release waits for core_n_ff
  assign io_reset_n = por_supply_ok && ext_reset_pin_n && !scan_reset_bit && !src_any && core_n_ff;
  // ==========================================================
  // delay counter
  assign dly.restart = src_any;
  assign dly.load_cyc = sel_cyc;
  rss_delay_cnt u_dly (
    .clk(aclk),
    .rst_n(aresetn),
    .dly(dly)
  );
  // ==========================================================
  // sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      rss_pkg::ST_HOLD:
      begin
        if (!src_any)
        begin
          nxt_state = rss_pkg::ST_STRETCH;
        end
      end
      rss_pkg::ST_STRETCH:
      begin
        if (src_any)
        begin
          nxt_state = rss_pkg::ST_HOLD;
        end
        else if (dly.done)
        begin
          nxt_state = rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_RUN:
      begin
        if (src_any)
        begin
          nxt_state = rss_pkg::ST_HOLD;
        end
      end
      default: nxt_state = rss_pkg::ST_HOLD;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= rss_pkg::ST_HOLD;
      core_n_ff <= 1'b0;
      pc_load_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      core_n_ff <= (nxt_state == rss_pkg::ST_RUN);
      pc_load_ff <= (nxt_state == rss_pkg::ST_RUN) && (state_ff != rss_pkg::ST_RUN);
    end
  end
  assign core_reset_n = core_n_ff;
  assign core_pc_load = pc_load_ff;
  assign core_pc = RESET_VECTOR;
  // ==========================================================
  // axi4-lite write channel
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_go;
  logic wr_ctrl;
  logic wr_cause;
  logic wr_hit;
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ctrl = wr_go && (awaddr_ff == rss_pkg::CTRL_OFS) && wstrb_ff[0];
  assign wr_cause = wr_go && (awaddr_ff == rss_pkg::CAUSE_OFS) && wstrb_ff[0];
  assign wr_hit = (awaddr_ff == rss_pkg::CTRL_OFS) || (awaddr_ff == rss_pkg::CAUSE_OFS);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  // ==========================================================
  // control and cause registers
  // a cause event in the clearing cycle is kept
  assign nxt_cause = (wr_cause ? (cause_ff & ~wdata_ff[4:0]) : cause_ff) | src_vec;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= rss_pkg::CTRL_RESET;
      cause_ff <= rss_pkg::CAUSE_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ff <= wdata_ff[1:0];
      end
      cause_ff <= nxt_cause;
    end
  end
  // ==========================================================
  // axi4-lite read channel
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [7:0] rd_addr;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign rd_hit = (rd_addr == rss_pkg::CTRL_OFS) || (rd_addr == rss_pkg::CAUSE_OFS)
    || (rd_addr == rss_pkg::STATUS_OFS) || (rd_addr == rss_pkg::DELAY_OFS);
  assign rd_mux = (rd_addr == rss_pkg::CTRL_OFS) ? {30'h0, ctrl_ff}
    : (rd_addr == rss_pkg::CAUSE_OFS) ? {27'h0, cause_ff}
    : (rd_addr == rss_pkg::STATUS_OFS) ? {24'h0, core_n_ff, state_ff, src_vec}
    : (rd_addr == rss_pkg::DELAY_OFS) ? sel_cyc
    : 32'h0;
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

// ===== rtl/rss_sync2.sv
// two flip-flop level synchroniser
`default_nettype none
module rss_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ===== sim/rss_seq_sva.sv
// assertions on the reset sequencer ports
`default_nettype none
module rss_seq_sva #(
  parameter int unsigned DLY_C_CYC = rss_pkg::TOUT_C_CYC,
  parameter int unsigned DLY_D_CYC = rss_pkg::TOUT_D_CYC,
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sources
  input wire logic por_supply_ok,
  input wire logic ext_reset_pin_n,
  input wire logic wdt_timeout,
  input wire logic wdt_reset_en,
  input wire logic bod_below_trigger,
  input wire logic scan_reset_bit,
  input wire logic [2:0] brownout_level_fuses,
  // outputs
  input wire logic io_reset_n,
  input wire logic core_reset_n,
  input wire logic core_pc_load,
  input wire logic [31:0] core_pc,
  input wire logic [2:0] brownout_level_sel,
  input wire logic brownout_detector_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MIN_A = DLY_C_CYC < 160 ? DLY_C_CYC : 160;
  localparam int unsigned MIN_CYC = DLY_D_CYC < MIN_A ? DLY_D_CYC : MIN_A;
  logic [15:0] quiet_ff;
  logic [15:0] nxt_quiet;
  logic src_any;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // cycles since any source was seen
  assign src_any = !por_supply_ok || !ext_reset_pin_n || bod_below_trigger || scan_reset_bit || wdt_timeout;
  assign nxt_quiet = src_any ? 16'h0 : quiet_ff + {15'h0, quiet_ff != 16'hFFFF};
  always_ff @(posedge aclk)
  begin
    quiet_ff <= aresetn ? nxt_quiet : 16'h0;
  end
  // ==========================================
  // properties
  AST_IO_CORE: assert property (!core_reset_n |-> !io_reset_n) else $error("io reset off in core reset");
  AST_SCAN_IO: assert property (scan_reset_bit |-> !io_reset_n) else $error("io not reset by scan");
  AST_POR_IO: assert property (!por_supply_ok |-> !io_reset_n) else $error("io not reset by supply");
  AST_SCAN_HOLD: assert property (scan_reset_bit [*5] |-> !core_reset_n) else $error("scan hold lost");
  AST_WDT: assert property (wdt_timeout && wdt_reset_en && core_reset_n |=> !core_reset_n)
    else $error("watchdog reset missed");
  AST_PC_LOAD: assert property ($rose(core_reset_n) |-> core_pc_load && core_pc == RESET_VECTOR)
    else $error("no vector load at release");
  AST_PC_PULSE: assert property (core_pc_load |=> !core_pc_load) else $error("vector load too long");
  AST_STRETCH: assert property ($rose(core_reset_n) |-> quiet_ff >= MIN_CYC) else $error("stretch short");
  AST_BOD_SEL: assert property (brownout_level_sel == brownout_level_fuses &&
    !(brownout_level_fuses == 3'h7 && brownout_detector_en)) else $error("brownout select wrong");
  AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind rss_seq rss_seq_sva #(.DLY_C_CYC(DLY_C_CYC), .DLY_D_CYC(DLY_D_CYC), .RESET_VECTOR(RESET_VECTOR)) u_sva (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .por_supply_ok, .ext_reset_pin_n, .wdt_timeout, .wdt_reset_en, .bod_below_trigger, .scan_reset_bit,
  .brownout_level_fuses, .io_reset_n, .core_reset_n, .core_pc_load, .core_pc, .brownout_level_sel,
  .brownout_detector_en);
`default_nettype wire

// ===== sim/rss_seq_tb.sv
// self-checking bench of the reset source sequencer
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module rss_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VEC = 32'h0000_0100; // arbitrary vector
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, por_supply_ok, ext_reset_pin_n, wdt_timeout;
  logic wdt_reset_en, bod_below_trigger, bod_above_upper, scan_reset_bit, io_reset_n, core_reset_n, core_pc_load;
  logic brownout_detector_en, supply_up, pin_hold, wdt_fire, supply_dip, scan_set;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, core_pc, rng, d;
  logic [3:0] s_axi_wstrb, clock_source_fuses;
  logic [1:0] s_axi_bresp, s_axi_rresp, startup_time_fuses, r;
  logic [2:0] brownout_level_fuses, brownout_level_sel;
  int fails, tests_run, cycles, n, e;
  int len_l[5] = '{10, 120, 1, 100, 10};
  // ==========================================
  // design and source model
  rss_seq #(.DLY_C_CYC(50), .DLY_D_CYC(80), .RESET_VECTOR(VEC)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .por_supply_ok, .ext_reset_pin_n, .wdt_timeout, .wdt_reset_en,
    .bod_below_trigger, .bod_above_upper, .scan_reset_bit, .startup_time_fuses, .clock_source_fuses,
    .brownout_level_fuses, .io_reset_n, .core_reset_n, .core_pc_load, .core_pc, .brownout_level_sel,
    .brownout_detector_en);
  rss_src_model u_src (.aclk, .supply_up, .pin_hold, .wdt_fire, .supply_dip, .scan_set, .por_supply_ok,
    .ext_reset_pin_n, .wdt_timeout, .bod_below_trigger, .bod_above_upper, .scan_reset_bit);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = !aclk;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int sel_cyc(input logic [1:0] st, input logic [3:0] cs);
    logic [1:0] idx;
    idx = (cs[3] && st < 2'h2) ? 2'h2 : st;
    return idx == 2'h0 ? 160 : idx == 2'h1 ? 4000 : idx == 2'h2 ? 50 : 80;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic drv(input int i, input logic v);
    case (i)
      0: supply_up <= !v;
      1: pin_hold <= v;
      2: wdt_fire <= v;
      3: supply_dip <= v;
      default: scan_set <= v;
    endcase
  endtask
  task automatic fire(input int i, input int len);
    drv(i, 1'b1);
    cyc(len);
    drv(i, 1'b0);
  endtask
  task automatic wait_up(output int k);
    k = 0;
    while (core_reset_n !== 1'b1 && k < 6000)
    begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      finish_test();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, supply_up, pin_hold, wdt_fire, supply_dip, scan_set} = '0;
    {startup_time_fuses, clock_source_fuses, brownout_level_fuses} = 9'h100;
    s_axi_wstrb = 4'hF;
    wdt_reset_en = 1'b1;
    rng = 32'h0000_9D3C;
    {fails, tests_run, cycles} = '0;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    axi_rd(rss_pkg::CTRL_OFS, d, r);
    `CHK(d, 32'h3, "ctrl reset")
    axi_rd(rss_pkg::CAUSE_OFS, d, r);
    `CHK(d, 32'h1, "cause reset")
    axi_rd(8'h10, d, r);
    `CHK({r, d}, 34'h200000000, "unmapped read")
    axi_wr(rss_pkg::STATUS_OFS, 32'h0, r);
    `CHK(r, 2'h2, "status write")
    `CHK({core_reset_n, io_reset_n}, 2'b00, "supply low")
    supply_up <= 1'b1;
    wait_up(n);
    `CHK(n >= 50 && n <= 70, 1'b1, "power up")
    `CHK(core_pc, VEC, "vector")
    axi_rd(rss_pkg::STATUS_OFS, d, r);
    `CHK(d, 32'h0000_00C0, "status run")
    $display("test power_up done");
    for (int i = 0; i < 5; i++)
    begin
      rng = xs(rng);
      e = sel_cyc(rng[1:0], rng[5:2]);
      startup_time_fuses <= rng[1:0];
      clock_source_fuses <= rng[5:2];
      brownout_level_fuses <= rng[8:6] % 3'h7;
      axi_wr(rss_pkg::CAUSE_OFS, 32'h1F, r);
      axi_rd(rss_pkg::DELAY_OFS, d, r);
      `CHK(d, e, "delay select")
      fire(i, len_l[i]);
      cyc(3);
      `CHK({core_reset_n, io_reset_n}, 2'b00, "held")
      wait_up(n);
      `CHK(n + 3 >= e && n + 3 <= e + 20, 1'b1, "stretch")
      axi_rd(rss_pkg::CAUSE_OFS, d, r);
      `CHK(d, 32'h1 << i, "cause")
    end
    $display("test sources done");
    fire(1, 40);
    fire(3, 30);
    cyc(20);
    `CHK(core_reset_n, 1'b1, "short pulses")
    wdt_reset_en <= 1'b0;
    fire(2, 1);
    cyc(5);
    `CHK(core_reset_n, 1'b1, "watchdog off")
    wdt_reset_en <= 1'b1;
    axi_wr(rss_pkg::CTRL_OFS, rng, r);
    axi_rd(rss_pkg::CTRL_OFS, d, r);
    `CHK(d, rng & 32'h3, "ctrl value")
    axi_wr(rss_pkg::CTRL_OFS, 32'h2, r);
    `CHK(brownout_detector_en, 1'b0, "bod off")
    fire(3, 100);
    cyc(10);
    `CHK(core_reset_n, 1'b1, "bod disabled")
    axi_wr(rss_pkg::CTRL_OFS, 32'h3, r);
    brownout_level_fuses <= 3'h7;
    cyc(2);
    `CHK({brownout_detector_en, brownout_level_sel}, 4'h7, "bod fuses")
    $display("test gating done");
    startup_time_fuses <= 2'h2;
    clock_source_fuses <= 4'h0;
    fire(4, 10);
    cyc(20);
    fire(4, 3);
    wait_up(n);
    `CHK(n >= 50 && n <= 70, 1'b1, "restart")
    $display("test restart done");
    finish_test();
  end
endmodule
`default_nettype wire

// ===== sim/rss_src_model.sv
// model of the reset sources outside the sequencer
`default_nettype none
module rss_src_model (
  // clock
  input wire logic aclk,
  // commands from the bench
  input wire logic supply_up,
  input wire logic pin_hold,
  input wire logic wdt_fire,
  input wire logic supply_dip,
  input wire logic scan_set,
  // source lines
  output logic por_supply_ok,
  output logic ext_reset_pin_n,
  output logic wdt_timeout,
  output logic bod_below_trigger,
  output logic bod_above_upper,
  output logic scan_reset_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hyst = 3'h0;
  logic wdt_q = 1'b0;
  // ==========================================
  // detector and pin levels
  assign por_supply_ok = supply_up;
  assign ext_reset_pin_n = !pin_hold;
  assign scan_reset_bit = scan_set;
  assign bod_below_trigger = supply_dip;
  assign bod_above_upper = hyst == 3'h0;
  assign wdt_timeout = wdt_q;
  always @(posedge aclk)
  begin
    wdt_q <= wdt_fire;
    hyst <= supply_dip ? 3'h4 : hyst - {2'h0, hyst != 3'h0};
  end
endmodule
`default_nettype wire
